//--- hdl/fault_monitor_pkg.sv
// Purpose : shared constants for the encoder fault monitor
// Assumes : plain register port, 8-bit address and data
// Notes   : offsets, bit positions and reset values live here; the bench repeats them as literals
package fault_monitor_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int POS_W  = 16;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ACC_ERR_OFS      = 8'h44;
    localparam logic [ADDR_W-1:0] USER_WARN_OFS    = 8'h47;
    localparam logic [ADDR_W-1:0] ACCEL_LIM_OFS    = 8'h50;
    localparam logic [ADDR_W-1:0] DEV_LIM_OFS      = 8'h51;
    localparam logic [ADDR_W-1:0] EVENT_HIGH_OFS   = 8'h52;
    localparam logic [ADDR_W-1:0] LIVE_HIGH_OFS    = 8'h53;
    localparam logic [ADDR_W-1:0] LIVE_LOW_OFS     = 8'h54;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFS     = 8'h55;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS     = 8'h56;
    localparam logic [ADDR_W-1:0] WARN_PERSIST_OFS = 8'h57;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ACC_ERR_BITS    = 4;
    localparam int ACC_INVALID_BIT = 0;
    localparam int ACC_DENIED_BIT  = 1;
    localparam int ACC_RES_BIT     = 2;
    localparam int ACC_FILE_BIT    = 3;
    localparam int WARN_BITS       = 8;

    localparam int EV_DEV_BIT = 1;
    localparam int EV_EST_BIT = 3;
    localparam int EV_SUM_BIT = 6;
    localparam int LQ_LOW_BIT = 2;

    localparam int EVB_BITS = 2;
    localparam int EVB_DEV  = 0;
    localparam int EVB_EST  = 1;

    localparam int IRQ_BITS = 4;
    localparam int IRQ_ACC  = 0;
    localparam int IRQ_WARN = 1;
    localparam int IRQ_DEV  = 2;
    localparam int IRQ_EST  = 3;

    // ------------------------------------------------------------
    // reset and default values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] DATA_ZERO         = 8'h00;
    localparam logic [DATA_W-1:0] ACCEL_LIM_RST     = 8'h10;
    localparam logic [DATA_W-1:0] DEV_LIM_RST       = 8'h20;
    localparam logic [DATA_W-1:0] LIVE_HIGH_DEFAULT = 8'h4A;
    localparam logic [DATA_W-1:0] LIVE_LOW_DEFAULT  = 8'h04;

endpackage : fault_monitor_pkg

//--- hdl/sticky_status_reg.sv
// Purpose : vector of acknowledgeable status bits
// Assumes : set, cause and clear are synchronous to core_clk
// Notes   : a set beats a clear in the same cycle
`timescale 1ns/100ps
`default_nettype none
module sticky_status_reg #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // bit control
    input  wire logic [WIDTH-1:0] setEvt,
    input  wire logic [WIDTH-1:0] cause,
    input  wire logic [WIDTH-1:0] permanent,
    input  wire logic [WIDTH-1:0] clearBits,
    // state
    output logic      [WIDTH-1:0] bits
);

    // permanent bits with a live cause come straight back after a clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bits <= '0;
        end else begin
            bits <= (bits & ~clearBits) | setEvt | (permanent & cause);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_perm_reassert: assert property (@(posedge core_clk) disable iff (sys_rst)
        (|(permanent & cause & clearBits)) |=> (|bits))
        else $error("permanent bit not raised again after clear");

    a_np_cleared: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clearBits[0] && !setEvt[0] && !(permanent[0] && cause[0])) |=> !bits[0])
        else $error("non-permanent bit survived its clear");

endmodule : sticky_status_reg
`default_nettype wire

//--- hdl/deviation_checker.sv
// Purpose : flags a fast position deviation beyond the tolerance
// Assumes : positions are unsigned counts of equal scale
// Notes   : tolerance is the sum of both user limits
`timescale 1ns/100ps
`default_nettype none
module deviation_checker
    import fault_monitor_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    // positions
    input  wire logic [POS_W-1:0]  mechPos,
    input  wire logic [POS_W-1:0]  calcPos,
    // limits
    input  wire logic [DATA_W-1:0] accelBoundaryLimit,
    input  wire logic [DATA_W-1:0] estimatorDeviationLimit,
    // result
    output logic                   overLimit
);

    logic [POS_W-1:0]  deviation;
    logic [DATA_W:0]   tolerance;

    assign deviation = (mechPos >= calcPos) ? (mechPos - calcPos) : (calcPos - mechPos);
    assign tolerance = {1'b0, accelBoundaryLimit} + {1'b0, estimatorDeviationLimit};

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            overLimit <= 1'b0;
        end else begin
            overLimit <= (deviation > POS_W'(tolerance));
        end
    end

    a_dev_over: assert property (@(posedge core_clk) disable iff (sys_rst)
        (deviation > POS_W'(tolerance)) |=> overLimit)
        else $error("deviation beyond tolerance not flagged");

endmodule : deviation_checker
`default_nettype wire

//--- hdl/encoder_fault_monitor.sv
// Purpose : fault and status monitoring for the drive side of a feedback link
// Assumes : event inputs are one-cycle pulses, levels are synchronous
// Notes   : registers are reached over a plain strobe port, data one cycle later
//
// Overview of operation
// - file access failure sets access bit 3
// - resource access failure sets access bit 2
// - refused access sets access bit 1
// - invalid argument or command sets bit 0
// - permanent bit returns after clear while cause
// - non-permanent bit goes away once cleared
// - deviation flag rises when error exceeds tolerance
// - tolerance comes from both user limits
// - deviation latched in event bit one, live mirror
// - estimator output mirrored in event bit three
// - startup shows default live notifications until online
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module encoder_fault_monitor (
    // clock and reset
    input  wire logic                               core_clk,
    input  wire logic                               sys_rst,
    // register port
    input  wire logic [fault_monitor_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [fault_monitor_pkg::DATA_W-1:0] wrData,
    input  wire logic                               wrStb,
    input  wire logic                               rdStb,
    output logic      [fault_monitor_pkg::DATA_W-1:0] rdData,
    // access error events
    input  wire logic                               fileAccessFail,
    input  wire logic                               resourceAccessFail,
    input  wire logic                               accessRefused,
    input  wire logic                               invalidAccess,
    // user warnings
    input  wire logic [fault_monitor_pkg::WARN_BITS-1:0] userWarnEvt,
    input  wire logic [fault_monitor_pkg::WARN_BITS-1:0] userWarnCause,
    // position and link state
    input  wire logic [fault_monitor_pkg::POS_W-1:0] mechPos,
    input  wire logic [fault_monitor_pkg::POS_W-1:0] calcPos,
    input  wire logic                               fastPosInvalid,
    input  wire logic                               encoderOnline,
    input  wire logic                               linkQualityMonitor,
    // status outputs
    output logic                                    deviationThresholdFlag,
    output logic                                    estimatorActive,
    output logic      [fault_monitor_pkg::DATA_W-1:0] liveStatusHigh,
    output logic      [fault_monitor_pkg::DATA_W-1:0] liveStatusLow,
    output logic                                    irq
);
    import fault_monitor_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [ACC_ERR_BITS-1:0] accSet;
    logic [ACC_ERR_BITS-1:0] accClear;
    logic [ACC_ERR_BITS-1:0] accessErrStatus;
    logic [WARN_BITS-1:0]    warnClear;
    logic [WARN_BITS-1:0]    userWarnStatus;
    logic [WARN_BITS-1:0]    warnPersist;
    logic [DATA_W-1:0]       accelBoundaryLimit;
    logic [DATA_W-1:0]       estimatorDeviationLimit;
    logic [EVB_BITS-1:0]     evSet;
    logic [EVB_BITS-1:0]     evClear;
    logic [EVB_BITS-1:0]     evBits;
    logic [IRQ_BITS-1:0]     irqSet;
    logic [IRQ_BITS-1:0]     irqClear;
    logic [IRQ_BITS-1:0]     irqStatus;
    logic [IRQ_BITS-1:0]     irqMask;
    logic [DATA_W-1:0]       eventHighView;
    logic [DATA_W-1:0]       next_rdData;
    logic                    devPrev;
    logic                    estPrev;
    logic                    devRise;
    logic                    estRise;
    logic                    summaryBit;
    logic                    wrAcc;
    logic                    wrWarn;
    logic                    wrEvent;
    logic                    wrIrq;

    // ------------------------------------------------------------
    // register write decode
    // ------------------------------------------------------------
    assign wrAcc   = wrStb && (regAddr == ACC_ERR_OFS);
    assign wrWarn  = wrStb && (regAddr == USER_WARN_OFS);
    assign wrEvent = wrStb && (regAddr == EVENT_HIGH_OFS);
    assign wrIrq   = wrStb && (regAddr == IRQ_STAT_OFS);

    // writing a one acknowledges that bit
    assign accClear  = wrAcc ? wrData[ACC_ERR_BITS-1:0] : '0;
    assign warnClear = wrWarn ? wrData[WARN_BITS-1:0] : '0;
    assign irqClear  = wrIrq ? wrData[IRQ_BITS-1:0] : '0;

    always_comb begin
        evClear = '0;
        if (wrEvent) begin
            evClear[EVB_DEV] = wrData[EV_DEV_BIT];
            evClear[EVB_EST] = wrData[EV_EST_BIT];
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            accelBoundaryLimit      <= ACCEL_LIM_RST;
            estimatorDeviationLimit <= DEV_LIM_RST;
        end else if (wrStb && (regAddr == ACCEL_LIM_OFS)) begin
            accelBoundaryLimit <= wrData;
        end else if (wrStb && (regAddr == DEV_LIM_OFS)) begin
            estimatorDeviationLimit <= wrData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irqMask     <= '0;
            warnPersist <= '0;
        end else if (wrStb && (regAddr == IRQ_MASK_OFS)) begin
            irqMask <= wrData[IRQ_BITS-1:0];
        end else if (wrStb && (regAddr == WARN_PERSIST_OFS)) begin
            warnPersist <= wrData[WARN_BITS-1:0];
        end
    end

    // ------------------------------------------------------------
    // encoder access error status
    // ------------------------------------------------------------
    always_comb begin
        accSet                  = '0;
        accSet[ACC_FILE_BIT]    = fileAccessFail;
        accSet[ACC_RES_BIT]     = resourceAccessFail;
        accSet[ACC_DENIED_BIT]  = accessRefused;
        accSet[ACC_INVALID_BIT] = invalidAccess;
    end

    // every access error bit is non-permanent
    sticky_status_reg #(
        .WIDTH     (ACC_ERR_BITS)
    ) u_access_err (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .setEvt    (accSet),
        .cause     (accSet),
        .permanent ('0),
        .clearBits (accClear),
        .bits      (accessErrStatus)
    );

    // ------------------------------------------------------------
    // user warning status, persistence chosen per bit
    // ------------------------------------------------------------
    sticky_status_reg #(
        .WIDTH     (WARN_BITS)
    ) u_user_warn (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .setEvt    (userWarnEvt),
        .cause     (userWarnCause),
        .permanent (warnPersist),
        .clearBits (warnClear),
        .bits      (userWarnStatus)
    );

    // ------------------------------------------------------------
    // deviation and estimator
    // ------------------------------------------------------------
    deviation_checker u_dev (
        .core_clk                (core_clk),
        .sys_rst                 (sys_rst),
        .mechPos                 (mechPos),
        .calcPos                 (calcPos),
        .accelBoundaryLimit      (accelBoundaryLimit),
        .estimatorDeviationLimit (estimatorDeviationLimit),
        .overLimit               (deviationThresholdFlag)
    );

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            estimatorActive <= 1'b0;
            devPrev         <= 1'b0;
            estPrev         <= 1'b0;
        end else begin
            estimatorActive <= fastPosInvalid;
            devPrev         <= deviationThresholdFlag;
            estPrev         <= estimatorActive;
        end
    end

    assign devRise = deviationThresholdFlag && !devPrev;
    assign estRise = estimatorActive && !estPrev;

    always_comb begin
        evSet          = '0;
        evSet[EVB_DEV] = devRise;
        evSet[EVB_EST] = estRise;
    end

    // latched event register, cleared by software after reading
    sticky_status_reg #(
        .WIDTH     (EVB_BITS)
    ) u_event_high (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .setEvt    (evSet),
        .cause     (evSet),
        .permanent ('0),
        .clearBits (evClear),
        .bits      (evBits)
    );

    assign summaryBit = (|evBits) || (|accessErrStatus) || (|userWarnStatus);

    always_comb begin
        eventHighView             = DATA_ZERO;
        eventHighView[EV_DEV_BIT] = evBits[EVB_DEV];
        eventHighView[EV_EST_BIT] = evBits[EVB_EST];
        eventHighView[EV_SUM_BIT] = summaryBit;
    end

    // ------------------------------------------------------------
    // live status, non-persisting
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            liveStatusHigh <= LIVE_HIGH_DEFAULT;
            liveStatusLow  <= LIVE_LOW_DEFAULT;
        end else if (!encoderOnline) begin
            liveStatusHigh <= LIVE_HIGH_DEFAULT;
            liveStatusLow  <= LIVE_LOW_DEFAULT;
        end else begin
            liveStatusHigh             <= DATA_ZERO;
            liveStatusHigh[EV_DEV_BIT] <= deviationThresholdFlag;
            liveStatusHigh[EV_EST_BIT] <= estimatorActive;
            liveStatusHigh[EV_SUM_BIT] <= deviationThresholdFlag || estimatorActive
                                          || summaryBit;
            liveStatusLow              <= DATA_ZERO;
            liveStatusLow[LQ_LOW_BIT]  <= linkQualityMonitor;
        end
    end

    // ------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------
    always_comb begin
        irqSet           = '0;
        irqSet[IRQ_ACC]  = |accSet;
        irqSet[IRQ_WARN] = |userWarnEvt;
        irqSet[IRQ_DEV]  = devRise;
        irqSet[IRQ_EST]  = estRise;
    end

    sticky_status_reg #(
        .WIDTH     (IRQ_BITS)
    ) u_irq_status (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .setEvt    (irqSet),
        .cause     (irqSet),
        .permanent ('0),
        .clearBits (irqClear),
        .bits      (irqStatus)
    );

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus & irqMask);
        end
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    always_comb begin
        if (regAddr == ACC_ERR_OFS) begin
            next_rdData = {{(DATA_W-ACC_ERR_BITS){1'b0}}, accessErrStatus};
        end else if (regAddr == USER_WARN_OFS) begin
            next_rdData = userWarnStatus;
        end else if (regAddr == ACCEL_LIM_OFS) begin
            next_rdData = accelBoundaryLimit;
        end else if (regAddr == DEV_LIM_OFS) begin
            next_rdData = estimatorDeviationLimit;
        end else if (regAddr == EVENT_HIGH_OFS) begin
            next_rdData = eventHighView;
        end else if (regAddr == LIVE_HIGH_OFS) begin
            next_rdData = liveStatusHigh;
        end else if (regAddr == LIVE_LOW_OFS) begin
            next_rdData = liveStatusLow;
        end else if (regAddr == IRQ_STAT_OFS) begin
            next_rdData = {{(DATA_W-IRQ_BITS){1'b0}}, irqStatus};
        end else if (regAddr == IRQ_MASK_OFS) begin
            next_rdData = {{(DATA_W-IRQ_BITS){1'b0}}, irqMask};
        end else if (regAddr == WARN_PERSIST_OFS) begin
            next_rdData = warnPersist;
        end else begin
            next_rdData = DATA_ZERO;
        end
    end

    // data stands only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdData <= DATA_ZERO;
        end else if (rdStb) begin
            rdData <= next_rdData;
        end else begin
            rdData <= DATA_ZERO;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_file_fail;
        fileAccessFail && !wrAcc;
    endsequence

    sequence s_dev_rise;
        deviationThresholdFlag && !devPrev;
    endsequence

    a_file_err_set: assert property (s_file_fail |=> accessErrStatus[ACC_FILE_BIT])
        else $error("file access failure not recorded");

    a_res_err_set: assert property (resourceAccessFail |=> accessErrStatus[ACC_RES_BIT])
        else $error("resource access failure not recorded");

    a_denied_set: assert property (accessRefused |=> accessErrStatus[ACC_DENIED_BIT])
        else $error("refused access not recorded");

    a_invalid_set: assert property (invalidAccess |=> accessErrStatus[ACC_INVALID_BIT])
        else $error("invalid access not recorded");

    a_acc_ack_clear: assert property (
        (wrAcc && wrData[ACC_FILE_BIT] && !fileAccessFail) |=> !accessErrStatus[ACC_FILE_BIT])
        else $error("acknowledged file error bit still set");

    a_dev_latched: assert property (
        s_dev_rise ##1 (!wrEvent && encoderOnline) |=>
            evBits[EVB_DEV] && (liveStatusHigh[EV_DEV_BIT] == $past(deviationThresholdFlag)))
        else $error("deviation event not latched and mirrored");

    a_est_latched: assert property (fastPosInvalid ##1 !estPrev |=> evBits[EVB_EST])
        else $error("estimator activity not latched");

    a_live_startup: assert property (
        !encoderOnline |=> (liveStatusHigh == LIVE_HIGH_DEFAULT) && (liveStatusLow == LIVE_LOW_DEFAULT))
        else $error("live status lacks startup notifications");

    a_read_acc_value: assert property (
        (rdStb && regAddr == ACC_ERR_OFS) |=> rdData[ACC_ERR_BITS-1:0] == $past(accessErrStatus))
        else $error("access error read returns wrong value");

endmodule : encoder_fault_monitor
`default_nettype wire

//--- tb/encoder_link_model.sv
// Purpose : far-side encoder, raises access error events
// Assumes : one request bit a cycle, one-cycle pulses out
// Notes   : link stays offline until powerUp
`timescale 1ns/100ps
`default_nettype none
module encoder_link_model (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // requests
    input  wire logic [3:0] errReq,
    input  wire logic       powerUp,
    // events
    output logic            fileAccessFail,
    output logic            resourceAccessFail,
    output logic            accessRefused,
    output logic            invalidAccess,
    output logic            encoderOnline
);
    always_ff @(posedge core_clk) begin
        fileAccessFail     <= !sys_rst && errReq[3];
        resourceAccessFail <= !sys_rst && errReq[2];
        accessRefused      <= !sys_rst && errReq[1];
        invalidAccess      <= !sys_rst && errReq[0];
    end
    // offline while in reset
    always_ff @(posedge core_clk) begin
        encoderOnline <= !sys_rst && powerUp;
    end
endmodule : encoder_link_model
`default_nettype wire

//--- tb/encoder_fault_monitor_tb_top.sv
// Purpose : self-checking bench of the fault monitor
// Assumes : fixed latencies of the register port
// Notes   : one task per scenario
`timescale 1ns/100ps
`default_nettype none
module encoder_fault_monitor_tb_top;
    import fault_monitor_pkg::*;
    logic core_clk, sys_rst, wrStb, rdStb, fpi, pwr;
    logic [7:0] regAddr, wrData, rdData, wEvt, wCause, lh, ll;
    logic [3:0] errReq;
    logic [15:0] mechPos, calcPos;
    logic fa, ra, ar, ia, onl, dtf, est, irq, lq;
    int n_fail, n_checks;
    encoder_link_model u_encoder_link_model (.core_clk(core_clk),
        .sys_rst(sys_rst), .errReq(errReq), .powerUp(pwr),
        .fileAccessFail(fa), .resourceAccessFail(ra),
        .accessRefused(ar), .invalidAccess(ia), .encoderOnline(onl));
    encoder_fault_monitor u_encoder_fault_monitor (.core_clk(core_clk),
        .sys_rst(sys_rst), .regAddr(regAddr), .wrData(wrData),
        .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
        .fileAccessFail(fa), .resourceAccessFail(ra),
        .accessRefused(ar), .invalidAccess(ia), .userWarnEvt(wEvt),
        .userWarnCause(wCause), .mechPos(mechPos), .calcPos(calcPos),
        .fastPosInvalid(fpi), .encoderOnline(onl),
        .linkQualityMonitor(lq), .deviationThresholdFlag(dtf),
        .estimatorActive(est), .liveStatusHigh(lh),
        .liveStatusLow(ll), .irq(irq));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        wrStb <= 1'b1; regAddr <= a; wrData <= d;
        @(posedge core_clk);
        wrStb <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        rdStb <= 1'b1; regAddr <= a;
        @(posedge core_clk);
        rdStb <= 1'b0;
        #1 d = rdData;
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] d;
        rd(8'h53, d); chk(d, 8'h4A);
        rd(8'h54, d); chk(d, 8'h04);
        rd(8'h50, d); chk(d, 8'h10);
        rd(8'h51, d); chk(d, 8'h20);
        rd(8'h60, d); chk(d, 8'h00);
        @(posedge core_clk) pwr <= 1'b1;
        cyc(3); chk(lh, 8'h00);
        chk(ll, 8'h00);
        @(posedge core_clk) lq <= 1'b1;
        cyc(2); chk(ll, 8'h04);
        @(posedge core_clk) lq <= 1'b0;
        cyc(2); chk(ll, 8'h00);
    endtask : t_reset
    task automatic t_access();
        logic [7:0] d;
        wr(8'h56, 8'h01);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk) errReq <= 4'(1 << i);
            @(posedge core_clk) errReq <= 4'h0;
            cyc(3); chk({7'h00, irq}, 8'h01);
            rd(8'h44, d); chk(d, 8'(1 << i));
            wr(8'h44, 8'(1 << i));
            wr(8'h55, 8'h01);
            rd(8'h44, d); chk(d, 8'h00);
            chk({7'h00, irq}, 8'h00);
        end
    endtask : t_access
    task automatic t_perm();
        logic [7:0] d;
        wr(8'h57, 8'h01);
        wCause <= 8'h01; wEvt <= 8'h03;
        @(posedge core_clk) wEvt <= 8'h00;
        wr(8'h47, 8'h03);
        rd(8'h47, d); chk(d, 8'h01);
        @(posedge core_clk) wCause <= 8'h00;
        wr(8'h47, 8'h01);
        rd(8'h47, d); chk(d, 8'h00);
    endtask : t_perm
    task automatic t_dev();
        logic [7:0] d;
        int k;
        @(posedge core_clk) mechPos <= 16'h0130;
        cyc(4); chk({7'h00, dtf}, 8'h00);
        wr(8'h51, 8'h1F);
        k = 0;
        while (dtf !== 1'b1 && k < 4) begin
            cyc(1); k++;
        end
        if (k == 4) begin
            n_fail++;
            end_of_test();
        end
        cyc(2); chk(lh & 8'h02, 8'h02);
        rd(8'h52, d); chk(d & 8'h02, 8'h02);
        chk(d & 8'h40, 8'h40);
        @(posedge core_clk) mechPos <= 16'h0100;
        wr(8'h52, 8'h02);
        rd(8'h52, d); chk(d & 8'h02, 8'h00);
    endtask : t_dev
    task automatic t_est();
        logic [7:0] d;
        @(posedge core_clk) fpi <= 1'b1;
        cyc(3); chk({7'h00, est}, 8'h01);
        rd(8'h52, d); chk(d & 8'h08, 8'h08);
        wr(8'h52, 8'h08);
        rd(8'h52, d); chk(d & 8'h08, 8'h00);
        @(posedge core_clk) fpi <= 1'b0;
    endtask : t_est
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        n_fail = 0; n_checks = 0;
        sys_rst = 1'b1; wrStb = 1'b0; rdStb = 1'b0; regAddr = 8'h00;
        wrData = 8'h00; errReq = 4'h0; pwr = 1'b0; fpi = 1'b0;
        wEvt = 8'h00; wCause = 8'h00; lq = 1'b0;
        mechPos = 16'h0100; calcPos = 16'h0100;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset(); t_access(); t_perm(); t_dev(); t_est();
        end_of_test();
    end
endmodule : encoder_fault_monitor_tb_top
`default_nettype wire
